// [logic/evp_exception_unit.sv]
// exception and interrupt vectoring: reset, trap, sleep, break,
// nonmaskable and maskable interrupts ranked onto one vector request
// assumes core pulses i_instr_done at each instruction or exception end
// and pulses i_vec_ack when it has taken the offered vector
`timescale 1ns/100ps
module evp_exception_unit #(
	parameter bit HAS_LVD = 1'b1,
	parameter bit HAS_SER_THREE = 1'b1
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// reset sources
	input wire logic i_reset_pin_n,
	input wire logic i_wdt_overflow,
	// core side
	input wire logic i_prog_exec,
	input wire logic i_instr_done,
	input wire logic i_condition_code_reg_i,
	input wire logic i_software_trap_instr,
	input wire logic [1:0] i_trap_num,
	input wire logic i_sleep_direct,
	input wire logic i_vec_ack,
	// nonmaskable sources, one-cycle pulses
	input wire logic i_nmi,
	input wire logic i_addr_break,
	// maskable sources, levels held by the source
	input wire logic i_ext_request_pin_zero,
	input wire logic i_low_voltage,
	input wire logic i_ext_request_pin_three,
	input wire logic i_wakeup_pins,
	input wire logic [evp_pkg::MTIMER_EV-1:0] i_mtimer_ev,
	input wire logic [evp_pkg::TIMER8_EV-1:0] i_timer8_ev,
	input wire logic [evp_pkg::SER_EV-1:0] i_serial_channel_one_ev,
	input wire logic [evp_pkg::SER_EV-1:0] i_serial_channel_two_ev,
	input wire logic [evp_pkg::SER_EV-1:0] i_serial_channel_three_ev,
	input wire logic i_adc_done,
	// vector request to the core
	output logic o_chip_reset,
	output logic o_exc_req,
	output logic [evp_pkg::VEC_W-1:0] o_vec_num,
	output logic [evp_pkg::ADDR_W-1:0] o_vec_addr
);
	import evp_pkg::*;

	evp_state_t state;
	evp_state_t next_state;
	logic [CNT_W-1:0] rst_cnt;
	logic [CNT_W-1:0] next_rst_cnt;
	logic next_chip_reset;
	logic next_exc_req;
	logic [VEC_W-1:0] next_vec_num;
	logic [ADDR_W-1:0] next_vec_addr;

	logic nmi_pend;
	logic brk_pend;
	logic slp_pend;
	logic trap_pend;
	logic [1:0] trap_sel;
	logic next_nmi_pend;
	logic next_brk_pend;
	logic next_slp_pend;
	logic next_trap_pend;
	logic [1:0] next_trap_sel;

	logic [NUM_VEC-1:0] req;
	logic win_valid;
	logic [VEC_W-1:0] win_vec;
	logic reset_cause;
	logic served;

	assign reset_cause = !i_reset_pin_n || i_wdt_overflow;
	assign served = (state == EVP_VECTOR) && i_vec_ack;

	// request vector, unmasked sources first
	always_comb begin
		req = '0;
		req[VEC_NMI] = nmi_pend;
		req[trap_vec(trap_sel)] = trap_pend;
		req[VEC_BREAK] = brk_pend;
		req[VEC_SLEEP] = slp_pend;
		if (!i_condition_code_reg_i) begin
			req[VEC_REQ_ZERO] = i_ext_request_pin_zero ||
				(HAS_LVD && i_low_voltage);
			req[VEC_REQ_THREE] = i_ext_request_pin_three;
			req[VEC_WAKEUP] = i_wakeup_pins;
			req[VEC_MTIMER] = |i_mtimer_ev;
			req[VEC_TIMER8] = |i_timer8_ev;
			req[VEC_SER_ONE] = |i_serial_channel_one_ev;
			req[VEC_ADC] = i_adc_done;
			req[VEC_SER_TWO] = |i_serial_channel_two_ev;
			req[VEC_SER_THREE] = HAS_SER_THREE &&
				(|i_serial_channel_three_ev);
		end
		req = req & ~RSVD_MASK;
	end

	// lowest number wins
	evp_prio_enc evp_prio_enc_i (
		.i_req(req),
		.o_valid(win_valid),
		.o_vec(win_vec)
	);

	// pending latches: a new event wins over the clear of its service
	always_comb begin
		next_nmi_pend = nmi_pend;
		next_brk_pend = brk_pend;
		next_slp_pend = slp_pend;
		next_trap_pend = trap_pend;
		next_trap_sel = trap_sel;
		if (state == EVP_RESET) begin
			next_nmi_pend = 1'b0;
			next_brk_pend = 1'b0;
			next_slp_pend = 1'b0;
			next_trap_pend = 1'b0;
		end else begin
			if (served && o_vec_num == VEC_NMI) begin
				next_nmi_pend = 1'b0;
			end
			if (served && o_vec_num == VEC_BREAK) begin
				next_brk_pend = 1'b0;
			end
			if (served && o_vec_num == VEC_SLEEP) begin
				next_slp_pend = 1'b0;
			end
			if (served && is_trap(o_vec_num)) begin
				next_trap_pend = 1'b0;
			end
			if (i_nmi) begin
				next_nmi_pend = 1'b1;
			end
			if (i_addr_break) begin
				next_brk_pend = 1'b1;
			end
			if (i_sleep_direct) begin
				next_slp_pend = 1'b1;
			end
			if (i_software_trap_instr && i_prog_exec) begin
				next_trap_pend = 1'b1;
				next_trap_sel = i_trap_num;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			nmi_pend <= 1'b0;
			brk_pend <= 1'b0;
			slp_pend <= 1'b0;
			trap_pend <= 1'b0;
			trap_sel <= 2'h0;
		end else begin
			nmi_pend <= next_nmi_pend;
			brk_pend <= next_brk_pend;
			slp_pend <= next_slp_pend;
			trap_pend <= next_trap_pend;
			trap_sel <= next_trap_sel;
		end
	end

	// sequencer: reset, run, offer vector
	always_comb begin
		next_state = state;
		next_rst_cnt = rst_cnt;
		next_chip_reset = o_chip_reset;
		next_exc_req = o_exc_req;
		next_vec_num = o_vec_num;
		next_vec_addr = o_vec_addr;
		if (reset_cause) begin
			next_state = EVP_RESET;
			next_chip_reset = 1'b1;
			next_exc_req = 1'b0;
			if (i_wdt_overflow) begin
				next_rst_cnt = CNT_W'(WDT_RST_CYCLES);
			end
		end else begin
			case (state)
				EVP_RESET: begin
					if (rst_cnt > CNT_ONE) begin
						next_rst_cnt = rst_cnt - CNT_ONE;
					end else begin
						next_rst_cnt = CNT_ZERO;
						next_state = EVP_VECTOR;
						next_chip_reset = 1'b0;
						next_exc_req = 1'b1;
						next_vec_num = VEC_RESET;
						next_vec_addr = vec_addr(VEC_RESET);
					end
				end
				EVP_RUN: begin
					if (i_instr_done && win_valid) begin
						next_state = EVP_VECTOR;
						next_exc_req = 1'b1;
						next_vec_num = win_vec;
						next_vec_addr = vec_addr(win_vec);
					end
				end
				EVP_VECTOR: begin
					if (i_vec_ack) begin
						next_state = EVP_RUN;
						next_exc_req = 1'b0;
					end
				end
				default: begin
					next_state = EVP_RESET;
					next_chip_reset = 1'b1;
					next_exc_req = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= EVP_RESET;
			rst_cnt <= CNT_ZERO;
			o_chip_reset <= 1'b1;
			o_exc_req <= 1'b0;
			o_vec_num <= VEC_RESET;
			o_vec_addr <= '0;
		end else begin
			state <= next_state;
			rst_cnt <= next_rst_cnt;
			o_chip_reset <= next_chip_reset;
			o_exc_req <= next_exc_req;
			o_vec_num <= next_vec_num;
			o_vec_addr <= next_vec_addr;
		end
	end

	// checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_reset_done;
		state == EVP_RESET && !reset_cause && rst_cnt <= CNT_ONE;
	endsequence

	sequence s_accept;
		state == EVP_RUN && !reset_cause && i_instr_done;
	endsequence

	a_reset_vec_zero: assert property (
		s_reset_done |=> o_exc_req && o_vec_num == VEC_RESET &&
			o_vec_addr == '0 && !o_chip_reset)
		else $error("reset did not vector through zero");

	a_reset_release: assert property (
		$rose(i_reset_pin_n) && !i_wdt_overflow && rst_cnt == CNT_ZERO
		|=> o_exc_req && o_vec_num == VEC_RESET)
		else $error("reset exception not started on pin release");

	a_wdt_reset_hold: assert property (
		i_wdt_overflow ##1 !reset_cause [*8]
		|-> o_chip_reset && state == EVP_RESET)
		else $error("watchdog reset released too early");

	a_trap_vector: assert property (
		$rose(o_exc_req) && is_trap(o_vec_num)
		|-> $past(trap_pend) && o_vec_num == trap_vec($past(trap_sel)))
		else $error("trap vector does not match trap number");

	a_trap_unmasked: assert property (
		s_accept ##0 trap_pend && !nmi_pend && i_condition_code_reg_i
		|=> o_exc_req && is_trap(o_vec_num))
		else $error("trap held off by mask bit");

	a_mask_holds: assert property (
		$rose(o_exc_req) && $past(i_condition_code_reg_i) &&
		o_vec_num != VEC_RESET |-> o_vec_num <= VEC_SLEEP)
		else $error("maskable interrupt taken while masked");

	a_nmi_first: assert property (
		s_accept ##0 nmi_pend
		|=> o_exc_req && o_vec_num == VEC_NMI && o_vec_addr == 16'h000e)
		else $error("nmi not served through vector 7");

	a_boundary_only: assert property (
		$rose(o_exc_req) && o_vec_num != VEC_RESET
		|-> $past(i_instr_done) && $past(state) == EVP_RUN)
		else $error("interrupt accepted inside an instruction");

	a_lowest_wins: assert property (
		s_accept ##0 win_valid
		|=> o_exc_req && (($past(req) & ((34'h1 << o_vec_num) - 34'h1))
			== '0))
		else $error("lower priority request served first");

	a_no_reserved: assert property (
		o_exc_req |-> !RSVD_MASK[o_vec_num])
		else $error("reserved vector offered");

	a_req_stands: assert property (
		o_exc_req && !i_vec_ack && !reset_cause
		|=> o_exc_req && $stable(o_vec_num) &&
			o_vec_addr == {9'h000, o_vec_num, 1'b0})
		else $error("vector request changed before ack");

endmodule

// [pkg/evp_pkg.sv]
// constants, state type and helpers of the exception vector unit
// assumes one core clock of 250 MHz and a synchronous active-high reset
package evp_pkg;

	localparam int VEC_W = 6;
	localparam int ADDR_W = 16;
	localparam int NUM_VEC = 34;
	localparam int CNT_W = 5;

	// vector numbers of the sources
	localparam logic [VEC_W-1:0] VEC_RESET = 6'h00;
	localparam logic [VEC_W-1:0] VEC_NMI = 6'h07;
	localparam logic [VEC_W-1:0] VEC_TRAP0 = 6'h08;
	localparam logic [VEC_W-1:0] VEC_TRAP3 = 6'h0b;
	localparam logic [VEC_W-1:0] VEC_BREAK = 6'h0c;
	localparam logic [VEC_W-1:0] VEC_SLEEP = 6'h0d;
	localparam logic [VEC_W-1:0] VEC_REQ_ZERO = 6'h0e;
	localparam logic [VEC_W-1:0] VEC_REQ_THREE = 6'h11;
	localparam logic [VEC_W-1:0] VEC_WAKEUP = 6'h12;
	localparam logic [VEC_W-1:0] VEC_MTIMER = 6'h15;
	localparam logic [VEC_W-1:0] VEC_TIMER8 = 6'h16;
	localparam logic [VEC_W-1:0] VEC_SER_ONE = 6'h17;
	localparam logic [VEC_W-1:0] VEC_ADC = 6'h19;
	localparam logic [VEC_W-1:0] VEC_SER_TWO = 6'h20;
	localparam logic [VEC_W-1:0] VEC_SER_THREE = 6'h21;

	// vectors 1 to 6 and 20 never carry a source
	localparam logic [NUM_VEC-1:0] RSVD_MASK = 34'h00010007e;

	// source group widths
	localparam int MTIMER_EV = 5;
	localparam int TIMER8_EV = 3;
	localparam int SER_EV = 4;

	// watchdog reset hold time
	localparam int CLK_PERIOD_NS = 4;
	localparam int WDT_RST_NS = 64;
	localparam int WDT_RST_CYCLES =
		(WDT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

	typedef enum logic [1:0] {
		EVP_RESET,
		EVP_RUN,
		EVP_VECTOR
	} evp_state_t;

	// two bytes per vector, address is twice the number
	function automatic logic [ADDR_W-1:0] vec_addr(
		input logic [VEC_W-1:0] v
	);
		vec_addr = {{(ADDR_W-VEC_W-1){1'b0}}, v, 1'b0};
	endfunction

	function automatic logic [VEC_W-1:0] trap_vec(input logic [1:0] n);
		trap_vec = VEC_TRAP0 + {4'h0, n};
	endfunction

	function automatic logic is_trap(input logic [VEC_W-1:0] v);
		is_trap = (v >= VEC_TRAP0) && (v <= VEC_TRAP3);
	endfunction

endpackage

// [logic/evp_prio_enc.sv]
// fixed-priority encoder: the lowest set request number wins
// assumes reserved request bits already forced low by the caller
`timescale 1ns/100ps
module evp_prio_enc (
	// request vector
	input wire logic [evp_pkg::NUM_VEC-1:0] i_req,
	// winner
	output logic o_valid,
	output logic [evp_pkg::VEC_W-1:0] o_vec
);
	import evp_pkg::*;

	always_comb begin
		o_valid = |i_req;
		o_vec = VEC_RESET;
		for (int i = NUM_VEC - 1; i >= 0; i--) begin
			if (i_req[i]) begin
				o_vec = VEC_W'(i);
			end
		end
	end

endmodule

// [test/evp_core_model.sv]
// core stand-in: ends instructions and takes offered vectors
// assumes a synchronous active-high reset on the core clock
`timescale 1ns/100ps
module evp_core_model (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// bench control
	input wire logic i_run,
	input wire logic [3:0] i_ack_dly,
	// vector request
	input wire logic i_exc_req,
	// core outputs
	output logic o_instr_done,
	output logic o_vec_ack
);
	logic [3:0] cnt;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cnt <= 4'h0;
			o_instr_done <= 1'b0;
			o_vec_ack <= 1'b0;
		end else begin
			// one-cycle ends, none while a vector waits
			o_instr_done <= i_run && !i_exc_req && !o_instr_done;
			o_vec_ack <= 1'b0;
			cnt <= 4'h0;
			if (i_exc_req && !o_vec_ack) begin
				cnt <= cnt + 4'h1;
				o_vec_ack <= (cnt >= i_ack_dly);
			end
		end
	end
endmodule

// [test/evp_exception_unit_tb.sv]
// bench of the exception vector unit with a core stand-in
// assumes the 250 MHz core clock and synchronous reset
`timescale 1ns/100ps
module evp_exception_unit_tb;
	import evp_pkg::*;
	logic clk = 1'b0, rst = 1'b1, rpin_n = 1'b1, wdt = 1'b0;
	logic run = 1'b0, pexec = 1'b1, mask = 1'b1, trap = 1'b0;
	logic slp = 1'b0, nmi = 1'b0, brk = 1'b0, p0 = 1'b0, lvd = 1'b0;
	logic p3 = 1'b0, wk = 1'b0, adc = 1'b0;
	logic [1:0] tnum = 2'h0;
	logic [3:0] dly = 4'h0, s1 = 4'h0, s2 = 4'h0, s3 = 4'h0;
	logic [4:0] mt = 5'h0;
	logic [2:0] t8 = 3'h0;
	logic done, ack, crst, req;
	logic [VEC_W-1:0] vn;
	logic [ADDR_W-1:0] va;
	int failures = 0, total_checks = 0, seed = 90340;
	int vt[10] = '{14, 14, 17, 18, 21, 22, 23, 25, 32, 33};

	always #2 clk = ~clk;

	evp_exception_unit evp_exception_unit_i (.i_core_clk(clk),
		.i_rst(rst), .i_reset_pin_n(rpin_n), .i_wdt_overflow(wdt),
		.i_prog_exec(pexec), .i_instr_done(done),
		.i_condition_code_reg_i(mask), .i_software_trap_instr(trap),
		.i_trap_num(tnum), .i_sleep_direct(slp), .i_vec_ack(ack),
		.i_nmi(nmi), .i_addr_break(brk), .i_ext_request_pin_zero(p0),
		.i_low_voltage(lvd), .i_ext_request_pin_three(p3),
		.i_wakeup_pins(wk), .i_mtimer_ev(mt), .i_timer8_ev(t8),
		.i_serial_channel_one_ev(s1), .i_serial_channel_two_ev(s2),
		.i_serial_channel_three_ev(s3), .i_adc_done(adc),
		.o_chip_reset(crst), .o_exc_req(req), .o_vec_num(vn),
		.o_vec_addr(va));

	evp_core_model evp_core_model_i (.i_core_clk(clk), .i_rst(rst),
		.i_run(run), .i_ack_dly(dly), .i_exc_req(req),
		.o_instr_done(done), .o_vec_ack(ack));

	task automatic stop_test();
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk_vec(input logic [VEC_W-1:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: vector %0d not %0d", $time, got, exp);
		end
	endtask

	task automatic chk_addr(input logic [ADDR_W-1:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: address %h not %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: flag %b not %b", $time, got, exp);
		end
	endtask

	// level sources; wide groups raise one random event
	task automatic set_src(input int i, input logic on);
		case (i)
		0: p0 <= on;
		1: lvd <= on;
		2: p3 <= on;
		3: wk <= on;
		4: mt <= on ? 5'(1 << ($unsigned($random(seed)) % 5)) : 5'h0;
		5: t8 <= on ? 3'(1 << ($unsigned($random(seed)) % 3)) : 3'h0;
		6: s1 <= on ? 4'(1 << ($unsigned($random(seed)) % 4)) : 4'h0;
		7: adc <= on;
		8: s2 <= on ? 4'(1 << ($unsigned($random(seed)) % 4)) : 4'h0;
		default: s3 <= on ? 4'(1 << ($unsigned($random(seed)) % 4)) : 4'h0;
		endcase
	endtask

	task automatic wait_req(input logic lvl);
		int k;
		k = 0;
		// always look at a negedge, never in the launching edge's step
		do begin
			@(negedge clk);
			k++;
		end while (req !== lvl && k < 80);
		if (req !== lvl) begin
			failures++;
			$display("Error %0t: request wait ran out", $time);
			stop_test();
		end
	endtask

	// offered vector is checked, its level sources drop
	task automatic take(input logic [VEC_W-1:0] exp);
		wait_req(1'b1);
		chk_vec(vn, exp);
		chk_addr(va, ADDR_W'({exp, 1'b0}));
		chk_bit(crst, 1'b0);
		@(posedge clk);
		for (int j = 0; j < 10; j++)
			if (vt[j] == exp)
				set_src(j, 1'b0);
		wait_req(1'b0);
		// hand back on a rising edge so callers drive there
		@(posedge clk);
	endtask

	task automatic pulse(input int i);
		@(posedge clk);
		case (i)
		0: nmi <= 1'b1;
		1: brk <= 1'b1;
		2: slp <= 1'b1;
		default: trap <= 1'b1;
		endcase
		@(posedge clk);
		{nmi, brk, slp, trap} <= 4'h0;
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk);
			chk_bit(req, 1'b0);
		end
		@(posedge clk);
	endtask

	always @(negedge clk)
		if (req === 1'b1)
			chk_bit(vn inside {[6'h01:6'h06], 6'h14}, 1'b0);

	initial begin
		int i;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		run <= 1'b1;
		// release is seen one edge later, and the vector is offered at that same edge
		repeat (2) @(negedge clk);
		chk_bit(req, 1'b1);
		take(VEC_RESET);
		rpin_n <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk_bit(crst, 1'b1);
		@(posedge clk);
		rpin_n <= 1'b1;
		repeat (2) @(negedge clk);
		chk_bit(req, 1'b1);
		take(VEC_RESET);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		@(negedge clk);
		chk_bit(crst, 1'b1);
		// still held in reset well into the watchdog hold time
		repeat (12) @(negedge clk);
		chk_bit(crst, 1'b1);
		chk_bit(req, 1'b0);
		take(VEC_RESET);
		for (i = 0; i < 4; i++) begin
			tnum <= 2'(i);
			pulse(3);
			take(VEC_TRAP0 + 6'(i));
		end
		set_src(0, 1'b1);
		idle(20);
		pulse(0);
		take(VEC_NMI);
		pulse(1);
		take(VEC_BREAK);
		pulse(2);
		take(VEC_SLEEP);
		mask <= 1'b0;
		take(VEC_REQ_ZERO);
		run <= 1'b0;
		pulse(0);
		idle(10);
		run <= 1'b1;
		take(VEC_NMI);
		mask <= 1'b1;
		for (i = 0; i < 10; i++)
			set_src(i, 1'b1);
		@(posedge clk);
		mask <= 1'b0;
		for (i = 0; i < 10; i++)
			if (i != 1)
				take(6'(vt[i]));
		repeat (30) begin
			i = $unsigned($random(seed)) % 10;
			dly <= 4'($random(seed));
			set_src(i, 1'b1);
			take(6'(vt[i]));
		end
		stop_test();
	end
endmodule
